// ---- rtl/gslm_top.sv ----
// Five step load manager, mains override and flashing relay
// Operation
// - At most five load steps; add from step one, remove highest supplied.
// - Power below add level for whole add start delay adds one step.
// - Add wait delay separates two add pulses; power must still be low.
// - Power above subtract level for whole start delay removes one step.
// - Subtract wait delay separates subtract pulses; if expired only start delay.
// - Each add or subtract output is a single quarter second pulse.
// - Each function input except force to start has programmable contact polarity.
// - Remote start assigned: mains failed while active, present while inactive.
// - With remote start assigned, mains lamps follow the remote start input.
// - Active disable auto start makes mains seem present, blocking starts.
// - Running genset is not stopped at once; normal waiting and cooldown run.
// - Lamps show mains present while disable or simulate active.
// - Remote start overrides disable auto start and force to start.
// - Delayed simulate set and input active off load: mains seems present.
// - Delayed simulate: start only with mains bad and simulate inactive.
// - Simulate rising while on load is held off for flashing on time.
// - Remote start and delayed simulate both enabled: remote start wins.
// - Flashing on and off times in hours; zero means two minutes.
// - Flashing relay toggles each time its current period elapses.
// - Priority assigned: master after each mains failure when signal applied.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "gslm_cfg.svh"
module gslm_top #(
  parameter int unsigned TICK_CYC = `GSLM_MS_CYC
) (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  reset_n_in,
  // Register port
  input  wire logic [5:0]            addr_in,
  input  wire logic [31:0]           wr_data_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rd_data_out,
  // Measurements and genset state
  input  wire logic [15:0]           power_in,
  input  wire logic                  mains_meas_ok_in,
  input  wire logic                  on_load_in,
  // Function input pins
  input  wire logic [`GSLM_FN_N-1:0] fn_pin_in,
  // Load step pulses
  output logic      [4:0]            add_pulse_out,
  output logic      [4:0]            sub_pulse_out,
  // Mains view and standby
  output logic                       mains_ok_out,
  output logic                       mains_lamp_out,
  output logic                       start_req_out,
  output logic                       master_out,
  output logic                       flash_relay_out
);
  logic rst_meta, rst_n;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  gslm_fn_if fn_bus ();
  logic [11:0] ctrl;
  logic [`GSLM_FN_N-1:0] invert;
  assign invert = {1'b0, ctrl[`GSLM_C_INV_LSB+7:`GSLM_C_INV_LSB+4] ^
                         ctrl[`GSLM_C_INV_LSB+3:`GSLM_C_INV_LSB]};

  gslm_fn_sync u_sync (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n),
    .pin_in    (fn_pin_in),
    .invert_in (invert),
    .fn        (fn_bus)
  );

  // Registers
  logic [15:0] add_lvl, sub_lvl, add_start, add_wait, sub_start, sub_wait;
  logic [7:0]  flash_on_h, flash_off_h;
  logic [11:0] next_ctrl;
  logic [15:0] next_add_lvl, next_sub_lvl, next_add_start, next_add_wait;
  logic [15:0] next_sub_start, next_sub_wait;
  logic [7:0]  next_flash_on_h, next_flash_off_h;
  logic [31:0] next_rd_data;

  // Time base
  logic [14:0] ms_cnt, next_ms_cnt;
  logic [9:0]  sec_cnt, next_sec_cnt;
  logic        ms_tick, sec_tick;
  assign ms_tick  = (ms_cnt == 15'(TICK_CYC - 1));
  assign sec_tick = ms_tick && (sec_cnt == `GSLM_MS_PER_S - 10'd1);

  // Load manager state
  gslm_pkg::gslm_lm_e lm_state, next_lm_state;
  logic [2:0]  steps, next_steps;
  logic [15:0] add_run, sub_run, add_gap, sub_gap, pulse_ms;
  logic [15:0] next_add_run, next_sub_run, next_add_gap, next_sub_gap, next_pulse_ms;
  logic [4:0]  next_add_pulse, next_sub_pulse;
  logic        below, above, fire_add, fire_sub, pulse_end;

  // Mains override state
  logic        sim_d, hold_on, next_sim_d, next_hold_on;
  logic [19:0] hold_s, next_hold_s, fl_s, next_fl_s;
  logic        next_mains_ok, next_start_req, next_master, next_flash;
  logic        rs_en, das_en, sim_en, pri_en, rs, das, sim, pri, force_start, sim_ok;

  assign rs_en  = ctrl[`GSLM_C_RS_EN];
  assign das_en = ctrl[`GSLM_C_DAS_EN];
  assign sim_en = ctrl[`GSLM_C_SIM_EN];
  assign pri_en = ctrl[`GSLM_C_PRI_EN];
  assign rs          = fn_bus.active[`GSLM_FN_RS];
  assign das         = fn_bus.active[`GSLM_FN_DAS];
  assign sim         = fn_bus.active[`GSLM_FN_SIM];
  assign pri         = fn_bus.active[`GSLM_FN_PRI];
  assign force_start = fn_bus.active[`GSLM_FN_FORCE];

  function automatic logic [19:0] hours_to_s(input logic [7:0] h);
    hours_to_s = (h == 8'h00) ? `GSLM_ZERO_H_S : 20'(h) * `GSLM_HOUR_S;
  endfunction : hours_to_s

  // Register port
  always_comb begin
    next_ctrl        = ctrl;
    next_add_lvl     = add_lvl;
    next_sub_lvl     = sub_lvl;
    next_add_start   = add_start;
    next_add_wait    = add_wait;
    next_sub_start   = sub_start;
    next_sub_wait    = sub_wait;
    next_flash_on_h  = flash_on_h;
    next_flash_off_h = flash_off_h;
    if (wr_in) begin
      unique case (addr_in)
        `GSLM_A_CTRL:      next_ctrl        = wr_data_in[11:0];
        `GSLM_A_ADD_LVL:   next_add_lvl     = wr_data_in[15:0];
        `GSLM_A_SUB_LVL:   next_sub_lvl     = wr_data_in[15:0];
        `GSLM_A_ADD_START: next_add_start   = wr_data_in[15:0];
        `GSLM_A_ADD_WAIT:  next_add_wait    = wr_data_in[15:0];
        `GSLM_A_SUB_START: next_sub_start   = wr_data_in[15:0];
        `GSLM_A_SUB_WAIT:  next_sub_wait    = wr_data_in[15:0];
        `GSLM_A_FLASH_ON:  next_flash_on_h  = wr_data_in[7:0];
        `GSLM_A_FLASH_OFF: next_flash_off_h = wr_data_in[7:0];
        default: ;
      endcase
    end
    next_rd_data = 32'h0000_0000;
    if (rd_in) begin
      unique case (addr_in)
        `GSLM_A_CTRL:      next_rd_data = {20'h00000, ctrl};
        `GSLM_A_ADD_LVL:   next_rd_data = {16'h0000, add_lvl};
        `GSLM_A_SUB_LVL:   next_rd_data = {16'h0000, sub_lvl};
        `GSLM_A_ADD_START: next_rd_data = {16'h0000, add_start};
        `GSLM_A_ADD_WAIT:  next_rd_data = {16'h0000, add_wait};
        `GSLM_A_SUB_START: next_rd_data = {16'h0000, sub_start};
        `GSLM_A_SUB_WAIT:  next_rd_data = {16'h0000, sub_wait};
        `GSLM_A_FLASH_ON:  next_rd_data = {24'h000000, flash_on_h};
        `GSLM_A_FLASH_OFF: next_rd_data = {24'h000000, flash_off_h};
        `GSLM_A_STATUS:    next_rd_data = {21'h00000, fn_bus.active, flash_relay_out,
                                           master_out, mains_ok_out, steps};
        default:           next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Load step manager
  assign below     = power_in < add_lvl;
  assign above     = power_in > sub_lvl;
  assign pulse_end = ms_tick && (pulse_ms == `GSLM_PULSE_MS - 16'd1);
  assign fire_add  = (lm_state == gslm_pkg::LM_IDLE) && below && (add_run >= add_start) &&
                     (add_gap >= add_wait) && (steps < `GSLM_STEPS);
  assign fire_sub  = (lm_state == gslm_pkg::LM_IDLE) && !fire_add && above &&
                     (sub_run >= sub_start) && (sub_gap >= sub_wait) &&
                     (steps != 3'd0);

  always_comb begin
    next_ms_cnt   = ms_tick ? 15'd0 : ms_cnt + 15'd1;
    next_sec_cnt  = sec_tick ? 10'd0 : (ms_tick ? sec_cnt + 10'd1 : sec_cnt);
    // Start timers restart whenever the power condition drops
    next_add_run  = !below ? 16'd0 : ((ms_tick && add_run != 16'hffff) ? add_run + 16'd1
                                                                       : add_run);
    next_sub_run  = !above ? 16'd0 : ((ms_tick && sub_run != 16'hffff) ? sub_run + 16'd1
                                                                       : sub_run);
    next_add_gap  = (ms_tick && add_gap != 16'hffff) ? add_gap + 16'd1 : add_gap;
    next_sub_gap  = (ms_tick && sub_gap != 16'hffff) ? sub_gap + 16'd1 : sub_gap;
    next_pulse_ms = ms_tick ? pulse_ms + 16'd1 : pulse_ms;
    next_lm_state = lm_state;
    next_steps     = steps;
    next_add_pulse = add_pulse_out;
    next_sub_pulse = sub_pulse_out;
    unique case (lm_state)
      gslm_pkg::LM_IDLE: begin
        next_pulse_ms = 16'd0;
        if (fire_add) begin
          next_lm_state  = gslm_pkg::LM_ADD;
          next_add_pulse = 5'(5'h01 << steps);
          next_steps     = steps + 3'd1;
          next_add_run   = 16'd0;
          next_add_gap   = 16'd0;
        end else if (fire_sub) begin
          next_lm_state  = gslm_pkg::LM_SUB;
          next_sub_pulse = 5'(5'h01 << (steps - 3'd1));
          next_steps     = steps - 3'd1;
          next_sub_run   = 16'd0;
          next_sub_gap   = 16'd0;
        end
      end
      gslm_pkg::LM_ADD, gslm_pkg::LM_SUB: begin
        if (pulse_end) begin
          next_lm_state  = gslm_pkg::LM_IDLE;
          next_add_pulse = 5'h00;
          next_sub_pulse = 5'h00;
        end
      end
      default: begin
        next_lm_state  = gslm_pkg::LM_IDLE;
        next_add_pulse = 5'h00;
        next_sub_pulse = 5'h00;
      end
    endcase
  end

  // Mains override, priority and flashing relay
  assign sim_ok = sim_en && sim && !hold_on;

  always_comb begin
    next_sim_d   = sim;
    next_hold_on = hold_on;
    next_hold_s  = hold_s;
    // Simulation on load is held back for the flashing on time
    if (!sim) begin
      next_hold_on = 1'b0;
    end else if (sim_en && !sim_d && on_load_in) begin
      next_hold_on = 1'b1;
      next_hold_s  = 20'd0;
    end else if (hold_on && sec_tick) begin
      next_hold_s = hold_s + 20'd1;
      if (hold_s + 20'd1 >= hours_to_s(flash_on_h)) begin
        next_hold_on = 1'b0;
      end
    end
    if (rs_en) begin
      next_mains_ok = !rs;
    end else if (das_en && das) begin
      next_mains_ok = 1'b1;
    end else if (sim_ok) begin
      next_mains_ok = 1'b1;
    end else begin
      next_mains_ok = mains_meas_ok_in;
    end
    // Stop is never commanded here; downstream sequencing does waiting and cooldown
    next_start_req = !next_mains_ok || (force_start && !rs_en);
    next_master = master_out;
    if (!pri_en) begin
      next_master = 1'b0;
    end else if (mains_ok_out && !next_mains_ok) begin
      next_master = pri;
    end
    next_fl_s  = fl_s;
    next_flash = flash_relay_out;
    if (sec_tick) begin
      if (fl_s + 20'd1 >= hours_to_s(flash_relay_out ? flash_on_h : flash_off_h)) begin
        next_fl_s  = 20'd0;
        next_flash = !flash_relay_out;
      end else begin
        next_fl_s = fl_s + 20'd1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `GSLM_R_CTRL;
      add_lvl <= `GSLM_R_LVL_ADD;
      sub_lvl <= `GSLM_R_LVL_SUB;
      add_start <= `GSLM_R_DLY;
      add_wait <= `GSLM_R_DLY;
      sub_start <= `GSLM_R_DLY;
      sub_wait <= `GSLM_R_DLY;
      flash_on_h <= `GSLM_R_FLASH;
      flash_off_h <= `GSLM_R_FLASH;
      rd_data_out <= 32'h0000_0000;
      ms_cnt <= 15'h0000;
      sec_cnt <= 10'h000;
      lm_state <= gslm_pkg::LM_IDLE;
      steps <= 3'h0;
      add_run <= 16'h0000;
      sub_run <= 16'h0000;
      add_gap <= 16'hffff;
      sub_gap <= 16'hffff;
      pulse_ms <= 16'h0000;
      add_pulse_out <= 5'h00;
      sub_pulse_out <= 5'h00;
      sim_d <= 1'b0;
      hold_on <= 1'b0;
      hold_s <= 20'h00000;
      fl_s <= 20'h00000;
      mains_ok_out <= 1'b1;
      mains_lamp_out <= 1'b1;
      start_req_out <= 1'b0;
      master_out <= 1'b0;
      flash_relay_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      add_lvl <= next_add_lvl;
      sub_lvl <= next_sub_lvl;
      add_start <= next_add_start;
      add_wait <= next_add_wait;
      sub_start <= next_sub_start;
      sub_wait <= next_sub_wait;
      flash_on_h <= next_flash_on_h;
      flash_off_h <= next_flash_off_h;
      rd_data_out <= next_rd_data;
      ms_cnt <= next_ms_cnt;
      sec_cnt <= next_sec_cnt;
      lm_state <= next_lm_state;
      steps <= next_steps;
      add_run <= next_add_run;
      sub_run <= next_sub_run;
      add_gap <= next_add_gap;
      sub_gap <= next_sub_gap;
      pulse_ms <= next_pulse_ms;
      add_pulse_out <= next_add_pulse;
      sub_pulse_out <= next_sub_pulse;
      sim_d <= next_sim_d;
      hold_on <= next_hold_on;
      hold_s <= next_hold_s;
      fl_s <= next_fl_s;
      mains_ok_out <= next_mains_ok;
      mains_lamp_out <= next_mains_ok;
      start_req_out <= next_start_req;
      master_out <= next_master;
      flash_relay_out <= next_flash;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  chk_step_limit: assert property (steps <= `GSLM_STEPS)
    else $error("step count above five");
  chk_add_onehot: assert property (fire_add |=> add_pulse_out == 5'(5'h01 << $past(steps)))
    else $error("add pulse on wrong step");
  chk_add_cause: assert property ($rose(|add_pulse_out) |-> $past(below && add_run >= add_start))
    else $error("add pulse without full low period");
  chk_add_spacing: assert property ($rose(|add_pulse_out) |-> $past(add_gap >= add_wait))
    else $error("add pulses too close");
  chk_sub_cause: assert property ($rose(|sub_pulse_out) |-> $past(above && sub_run >= sub_start))
    else $error("subtract pulse without full high period");
  chk_sub_spacing: assert property (fire_sub |-> sub_gap >= sub_wait ##1 sub_gap == 16'd0)
    else $error("subtract pulses too close");
  chk_pulse_end: assert property (lm_state != gslm_pkg::LM_IDLE && pulse_end
                                  |=> (add_pulse_out | sub_pulse_out) == 5'h00)
    else $error("pulse not ended at quarter second");
  chk_rs_mains: assert property (rs_en && rs ##1 rs_en |-> !mains_ok_out)
    else $error("remote start did not fail mains");
  chk_das_mains: assert property (!rs_en && das_en && das |=> mains_ok_out)
    else $error("disable auto start did not hold mains present");
  chk_lamp_follow: assert property (rs_en |=> mains_lamp_out == !$past(rs))
    else $error("mains lamp does not follow remote start");

  cov_add_step: cover property (fire_add ##1 lm_state == gslm_pkg::LM_ADD);
  cov_sub_step: cover property (fire_sub && steps == 3'd5);
  cov_flash: cover property ($changed(flash_relay_out));
  cov_master: cover property ($rose(master_out));
endmodule : gslm_top

// ---- inc/gslm_cfg.svh ----
// Constants of the load step manager and mains override block
`ifndef GSLM_CFG_SVH
`define GSLM_CFG_SVH

// Clock and time base
`define GSLM_CLK_HZ      20000000
`define GSLM_TICK_MS     1
`define GSLM_MS_CYC      ((`GSLM_CLK_HZ / 1000) * `GSLM_TICK_MS)
`define GSLM_MS_PER_S    10'd1000
`define GSLM_PULSE_MS    16'd250
`define GSLM_ZERO_H_S    20'd120
`define GSLM_HOUR_S      20'd3600

// Load steps and function inputs
`define GSLM_STEPS       3'd5
`define GSLM_FN_N        5
`define GSLM_FN_RS       0
`define GSLM_FN_DAS      1
`define GSLM_FN_SIM      2
`define GSLM_FN_PRI      3
`define GSLM_FN_FORCE    4

// Register byte addresses
`define GSLM_A_CTRL      6'h00
`define GSLM_A_ADD_LVL   6'h04
`define GSLM_A_SUB_LVL   6'h08
`define GSLM_A_ADD_START 6'h0c
`define GSLM_A_ADD_WAIT  6'h10
`define GSLM_A_SUB_START 6'h14
`define GSLM_A_SUB_WAIT  6'h18
`define GSLM_A_FLASH_ON  6'h1c
`define GSLM_A_FLASH_OFF 6'h20
`define GSLM_A_STATUS    6'h24

// Control register fields
`define GSLM_C_RS_EN     0
`define GSLM_C_DAS_EN    1
`define GSLM_C_SIM_EN    2
`define GSLM_C_PRI_EN    3
`define GSLM_C_INV_LSB   4

// Reset values
`define GSLM_R_CTRL      12'h000
`define GSLM_R_LVL_ADD   16'h0000
`define GSLM_R_LVL_SUB   16'hffff
`define GSLM_R_DLY       16'h03e8
`define GSLM_R_FLASH     8'h00

`endif

// ---- inc/gslm_pkg.sv ----
// Types of the load step manager and mains override block
package gslm_pkg;
  typedef enum logic [1:0] {
    LM_IDLE = 2'b00,
    LM_ADD  = 2'b01,
    LM_SUB  = 2'b10
  } gslm_lm_e;
endpackage : gslm_pkg

// ---- inc/gslm_fn_if.sv ----
// Qualified function input levels between synchroniser and core
`timescale 1ns/1ns
interface gslm_fn_if;
  logic [4:0] active;
  modport src (output active);
  modport dst (input active);
endinterface : gslm_fn_if

// ---- rtl/gslm_fn_sync.sv ----
// Function input synchroniser with per-input contact polarity
`timescale 1ns/1ns
`include "gslm_cfg.svh"
module gslm_fn_sync (
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  // Raw pins and polarity
  input  wire logic [`GSLM_FN_N-1:0]  pin_in,
  input  wire logic [`GSLM_FN_N-1:0]  invert_in,
  // Qualified levels
  gslm_fn_if.src                      fn
);
  logic [`GSLM_FN_N-1:0] meta;
  logic [`GSLM_FN_N-1:0] held;
  logic [`GSLM_FN_N-1:0] next_meta;
  logic [`GSLM_FN_N-1:0] next_held;

  always_comb begin
    next_meta = pin_in;
    next_held = meta;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      held <= '0;
    end else begin
      meta <= next_meta;
      held <= next_held;
    end
  end

  // NO/NC and supply side fold into one inversion per input
  for (genvar i = 0; i < `GSLM_FN_N; i++) begin : g_pol
    assign fn.active[i] = held[i] ^ invert_in[i];
  end
endmodule : gslm_fn_sync

// ---- dv/gslm_load_model.sv ----
// Contactor bank that steps genset power on add and subtract pulses
`timescale 1ns/1ns
module gslm_load_model #(
  parameter int unsigned STEP_W = 100
) (
  // Clock
  input  wire logic        mclk_in,
  // Pulses from the controller and base load
  input  wire logic [4:0]  add_pulse_in,
  input  wire logic [4:0]  sub_pulse_in,
  input  wire logic [15:0] base_in,
  // Measured power and closed steps
  output logic      [15:0] power_out,
  output logic      [2:0]  steps_out
);
  logic [4:0] prev_add = 5'h00;
  logic [4:0] prev_sub = 5'h00;

  initial steps_out = 3'h0;
  // Contactors act on the pulse edge; a long pulse is not a second step
  always @(posedge mclk_in) begin
    prev_add <= add_pulse_in;
    prev_sub <= sub_pulse_in;
    if (|(add_pulse_in & ~prev_add)) begin
      steps_out <= steps_out + 3'h1;
    end else if (|(sub_pulse_in & ~prev_sub)) begin
      steps_out <= steps_out - 3'h1;
    end
  end
  assign power_out = base_in + 16'(STEP_W) * {13'h0000, steps_out};
endmodule : gslm_load_model

// ---- dv/tb.sv ----
// Self-checking bench of the load step manager and mains override
`timescale 1ns/1ns
`include "gslm_cfg.svh"
module tb;
  typedef struct {
    logic [11:0] ctrl;
    logic [4:0]  pin;
    logic        meas;
    logic        ok;
    logic        st;
  } gslm_row_s;
  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [5:0]  addr_in = 6'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        mains_meas_ok_in = 1'b1;
  logic        on_load_in = 1'b0;
  logic [4:0]  fn_pin_in = 5'h00;
  logic [15:0] base = 16'h0000;
  logic [31:0] rd_data_out;
  logic [15:0] power_in;
  logic [4:0]  add_pulse_out;
  logic [4:0]  sub_pulse_out;
  logic        mains_ok_out;
  logic        mains_lamp_out;
  logic        start_req_out;
  logic        master_out;
  logic        flash_relay_out;
  logic [4:0]  prev_p = 5'h00;
  logic [31:0] rdv;
  logic [2:0]  load_steps;
  logic [31:0] rst_val [11];
  gslm_row_s   rows [15];
  int          err_count = 0;
  int          comparisons = 0;
  int          n_pulse = 0;
  int          pulses;
  int          gap;

  gslm_top #(.TICK_CYC(4)) i_dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .power_in(power_in), .mains_meas_ok_in(mains_meas_ok_in), .on_load_in(on_load_in),
    .fn_pin_in(fn_pin_in), .add_pulse_out(add_pulse_out), .sub_pulse_out(sub_pulse_out),
    .mains_ok_out(mains_ok_out), .mains_lamp_out(mains_lamp_out),
    .start_req_out(start_req_out), .master_out(master_out),
    .flash_relay_out(flash_relay_out));
  gslm_load_model #(.STEP_W(100)) i_load (
    .mclk_in(mclk_in), .add_pulse_in(add_pulse_out), .sub_pulse_in(sub_pulse_out),
    .base_in(base), .power_out(power_in), .steps_out(load_steps));

  always #25 mclk_in = ~mclk_in;
  // Counts every new pulse on either output group
  always @(posedge mclk_in) begin
    prev_p <= add_pulse_out | sub_pulse_out;
    if (|((add_pulse_out | sub_pulse_out) & ~prev_p)) n_pulse <= n_pulse + 1;
  end

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    rdv = rd_data_out;
  endtask : rd

  // Waits for a pulse, checks its step and width; gap is the wait in cycles
  task automatic get_pulse(input logic add, input int bitn, input int tmax);
    logic [4:0] p;
    int         w;
    p   = 5'h00;
    gap = 0;
    while (p === 5'h00 && gap < tmax) begin
      @(posedge mclk_in);
      #1;
      p = add ? add_pulse_out : sub_pulse_out;
      gap++;
    end
    check(p === (5'h01 << bitn), "pulse on wrong step or missing");
    w = 0;
    while (p !== 5'h00 && w < 1100) begin
      @(posedge mclk_in);
      #1;
      p = add ? add_pulse_out : sub_pulse_out;
      w++;
    end
    check(w >= 996 && w <= 1004, "pulse width");
  endtask : get_pulse

  task automatic set_in(input logic [11:0] c, input logic [4:0] pin, input logic meas);
    wr(`GSLM_A_CTRL, {20'h0, c});
    fn_pin_in        <= pin;
    mains_meas_ok_in <= meas;
    repeat (8) @(posedge mclk_in);
    #1;
  endtask : set_in

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    rst_val = '{32'h0, 32'h0, 32'hffff, 32'h3e8, 32'h3e8, 32'h3e8, 32'h3e8,
                32'h0, 32'h0, 32'h8, 32'h0};
    rows = '{'{12'h000, 5'h00, 1'b1, 1'b1, 1'b0}, '{12'h000, 5'h00, 1'b0, 1'b0, 1'b1},
             '{12'h001, 5'h01, 1'b1, 1'b0, 1'b1}, '{12'h001, 5'h00, 1'b0, 1'b1, 1'b0},
             '{12'h002, 5'h02, 1'b0, 1'b1, 1'b0}, '{12'h002, 5'h00, 1'b0, 1'b0, 1'b1},
             '{12'h003, 5'h03, 1'b1, 1'b0, 1'b1}, '{12'h001, 5'h10, 1'b1, 1'b1, 1'b0},
             '{12'h000, 5'h10, 1'b1, 1'b1, 1'b1}, '{12'h004, 5'h04, 1'b0, 1'b1, 1'b0},
             '{12'h004, 5'h00, 1'b0, 1'b0, 1'b1}, '{12'h005, 5'h05, 1'b0, 1'b0, 1'b1},
             '{12'h011, 5'h00, 1'b1, 1'b0, 1'b1}, '{12'h101, 5'h00, 1'b1, 1'b0, 1'b1},
             '{12'h111, 5'h00, 1'b1, 1'b1, 1'b0}};
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    // Mains view under every override mode
    foreach (rows[i]) begin
      set_in(rows[i].ctrl, rows[i].pin, rows[i].meas);
      check(mains_ok_out === rows[i].ok, "effective mains");
      check(mains_lamp_out === rows[i].ok, "mains lamp");
      check(start_req_out === rows[i].st, "start request");
    end
    set_in(12'h008, 5'h08, 1'b1);
    set_in(12'h008, 5'h08, 1'b0);
    check(master_out === 1'b1, "master with priority applied");
    set_in(12'h008, 5'h00, 1'b1);
    set_in(12'h008, 5'h00, 1'b0);
    check(master_out === 1'b0, "slave without priority");
    set_in(12'h000, 5'h00, 1'b1);
    // Read-only and unmapped places ignore writes
    wr(`GSLM_A_STATUS, 32'hffffffff);
    wr(6'h28, 32'hffffffff);
    for (int i = 0; i < 11; i++) begin
      rd(6'(4 * i));
      check(rdv === rst_val[i], "register reset value");
    end
    check(flash_relay_out === 1'b0, "flash relay idle level");
    // Load steps: five adds, then five subtracts
    wr(`GSLM_A_ADD_START, 32'd5);
    wr(`GSLM_A_ADD_WAIT, 32'd400);
    wr(`GSLM_A_SUB_START, 32'd5);
    wr(`GSLM_A_SUB_WAIT, 32'd400);
    wr(`GSLM_A_SUB_LVL, 32'd3000);
    wr(`GSLM_A_ADD_LVL, 32'd1000);
    get_pulse(1'b1, 0, 60);
    for (int s = 1; s < 5; s++) begin
      get_pulse(1'b1, s, 800);
      check(gap >= 592 && gap <= 700, "add spacing");
    end
    pulses = n_pulse;
    repeat (2000) @(posedge mclk_in);
    check(n_pulse == pulses, "add beyond five steps");
    rd(`GSLM_A_STATUS);
    check(rdv[2:0] === 3'd5, "step count");
    check(load_steps === 3'd5, "contactors closed");
    base <= 16'd5000;
    get_pulse(1'b0, 4, 60);
    for (int s = 3; s >= 0; s--) begin
      get_pulse(1'b0, s, 800);
      check(gap >= 592 && gap <= 700, "subtract spacing");
    end
    pulses = n_pulse;
    repeat (2000) @(posedge mclk_in);
    check(n_pulse == pulses, "subtract below step zero");
    check(load_steps === 3'd0, "contactors open");
    // Low power interrupted before the start delay never adds
    repeat (5) begin
      base <= 16'd0;
      repeat (14) @(posedge mclk_in);
      base <= 16'd2000;
      repeat (4) @(posedge mclk_in);
    end
    check(n_pulse == pulses, "start timer not restarted");
    base <= 16'd0;
    get_pulse(1'b1, 0, 60);
    check(gap >= 16, "add before start delay");
    // Simulate rising while on load stays suppressed
    @(posedge mclk_in);
    on_load_in <= 1'b1;
    set_in(12'h004, 5'h00, 1'b0);
    @(posedge mclk_in);
    fn_pin_in <= 5'h04;
    repeat (8) @(posedge mclk_in);
    #1;
    check(mains_ok_out === 1'b0 && start_req_out === 1'b1, "simulate held off");
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    #1;
    check(mains_ok_out === 1'b1 && start_req_out === 1'b0, "reset in mid run");
    @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(`GSLM_A_CTRL);
    check(rdv === 32'h0, "control after reset");
    test_done();
  end

  initial begin
    repeat (60000) @(posedge mclk_in);
    err_count++;
    test_done();
  end
endmodule : tb
